// >>> hw/bwl_pkg.sv
package bwl_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_WAFERS = 10;
    localparam int WAFER_OUTS = 4;
    localparam int CODE_W     = 9;
    localparam int TYPE_W     = 3;
    localparam int CONST_W    = 16;
    localparam int NUM_CONSTS = 10;
    localparam int NUM_ALARMS = 5;
    localparam int NUM_EVENTS = 5;
    localparam int NUM_ERRS   = 4;
    localparam int NUM_STATUS = 5;
    localparam int TIME_SIGS  = 128;
    localparam int WAFER_CFG_W = TYPE_W + 3 * CODE_W;
    localparam int ADDR_W     = 4;

    // ------------------------------------------------------------------
    // Calculation kinds
    // ------------------------------------------------------------------
    localparam logic [TYPE_W-1:0] TYPE_OR3     = 3'h2;
    localparam logic [TYPE_W-1:0] TYPE_AND3    = 3'h3;
    localparam logic [TYPE_W-1:0] TYPE_OR_AND  = 3'h4;
    localparam logic [TYPE_W-1:0] TYPE_AND_OR  = 3'h5;
    localparam logic [TYPE_W-1:0] TYPE_RESET   = 3'h1;

    // ------------------------------------------------------------------
    // Input source codes
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] SRC_NONE      = 9'h000;
    localparam logic [CODE_W-1:0] SRC_ALARM_LO  = 9'h003;
    localparam logic [CODE_W-1:0] SRC_ALARM_HI  = 9'h007;
    localparam logic [CODE_W-1:0] SRC_EVENT_LO  = 9'h014;
    localparam logic [CODE_W-1:0] SRC_EVENT_HI  = 9'h018;
    localparam logic [CODE_W-1:0] SRC_RESULT_LO = 9'h01E;
    localparam logic [CODE_W-1:0] SRC_RESULT_HI = 9'h045;
    localparam logic [CODE_W-1:0] SRC_CONST_LO  = 9'h046;
    localparam logic [CODE_W-1:0] SRC_CONST_HI  = 9'h04F;
    localparam logic [CODE_W-1:0] SRC_UNDER     = 9'h05E;
    localparam logic [CODE_W-1:0] SRC_OVER      = 9'h05F;
    localparam logic [CODE_W-1:0] SRC_RANGE_ERR = 9'h062;
    localparam logic [CODE_W-1:0] SRC_IN_ERR    = 9'h067;
    localparam logic [CODE_W-1:0] SRC_AUTO_MAN  = 9'h068;
    localparam logic [CODE_W-1:0] SRC_RUN_STBY  = 9'h069;
    localparam logic [CODE_W-1:0] SRC_AT_RUN    = 9'h06B;
    localparam logic [CODE_W-1:0] SRC_AT_NORM   = 9'h06C;
    localparam logic [CODE_W-1:0] SRC_AT_LOW    = 9'h06D;
    localparam logic [CODE_W-1:0] SRC_ABS_LO    = 9'h0AA;
    localparam logic [CODE_W-1:0] SRC_ABS_HI    = 9'h129;
    localparam logic [CODE_W-1:0] SRC_REL_LO    = 9'h12C;
    localparam logic [CODE_W-1:0] SRC_REL_HI    = 9'h1AB;

    // ------------------------------------------------------------------
    // Scan address reset and last values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_LAST  = 4'h9;

    typedef enum logic [1:0] {
        BWL_IDLE = 2'b00,
        BWL_SCAN = 2'b01
    } bwl_state_e;
endpackage

// >>> hw/bwl_cfg_mem.sv
`timescale 1ns/10ps
module bwl_cfg_mem #(
    parameter int DEPTH = 10,
    parameter int WIDTH = 30,
    parameter int AW    = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    // Contents have no reset: an unwritten wafer reads as undefined until set.
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule // bwl_cfg_mem

// >>> hw/bwl_wafer_unit.sv
`timescale 1ns/10ps
// Function
// - One on/off setting enables the whole calculation; when off no result is made or driven.
// - Any wafer result can be routed to a digital output channel or to a lamp.
// - Up to ten wafers are each evaluated with their own type, inputs and outputs.
// - A per-wafer type selector picks one of four calculation kinds; any other type drives all four outputs low.
// - Each wafer holds a type, three input selectors and four outputs in one block.
// - A wafer output may feed the input of another wafer.
// - Codes 30 to 69 select wafer results by wafer then output, 30 being wafer one output one.
// - Code 69 is wafer ten output four, four codes per wafer.
// - Codes 3 to 7 select alarms one to five.
// - Codes 20 to 24 select the off, run, hold, guarantee soak and end event flags.
// - Ten user constants are selected by codes 70 to 79, nonzero meaning true.
// - Codes 104, 105, 107, 108 and 109 select the operation status bits.
// - Codes 170 to 297 select absolute step time signals, ramp then soak per step.
// - Codes 300 to 427 select relative step time signals, ramp then soak per step.
module bwl_wafer_unit #(
    parameter int NUM_DO  = 4,
    parameter int NUM_LED = 4
) (
    input  wire logic                                        ref_clk_i,
    input  wire logic                                        nrst_i,
    input  wire logic                                        calc_enable_i,
    input  wire logic                                        cfg_we_i,
    input  wire logic [bwl_pkg::ADDR_W-1:0]                  cfg_wafer_i,
    input  wire logic [bwl_pkg::WAFER_CFG_W-1:0]             cfg_data_i,
    input  wire logic [bwl_pkg::NUM_CONSTS*bwl_pkg::CONST_W-1:0] user_const_i,
    input  wire logic [bwl_pkg::NUM_ALARMS-1:0]              alarm_i,
    input  wire logic [bwl_pkg::NUM_EVENTS-1:0]              event_i,
    input  wire logic [bwl_pkg::NUM_ERRS-1:0]                in_err_i,
    input  wire logic [bwl_pkg::NUM_STATUS-1:0]              op_status_i,
    input  wire logic [bwl_pkg::TIME_SIGS-1:0]               abs_time_i,
    input  wire logic [bwl_pkg::TIME_SIGS-1:0]               rel_time_i,
    input  wire logic [NUM_DO*bwl_pkg::CODE_W-1:0]           do_sel_i,
    input  wire logic [NUM_LED*bwl_pkg::CODE_W-1:0]          led_sel_i,
    output logic      [bwl_pkg::NUM_WAFERS*bwl_pkg::WAFER_OUTS-1:0] result_o,
    output logic      [NUM_DO-1:0]                           do_o,
    output logic      [NUM_LED-1:0]                          led_o
);
    localparam int NRES  = bwl_pkg::NUM_WAFERS * bwl_pkg::WAFER_OUTS;
    localparam int EXT_W = bwl_pkg::NUM_ALARMS + bwl_pkg::NUM_EVENTS + bwl_pkg::NUM_ERRS
                         + bwl_pkg::NUM_STATUS + 2 * bwl_pkg::TIME_SIGS;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Status pins come from other parts of the controller on unrelated timing.
    logic [EXT_W-1:0] ext_meta_reg;
    logic [EXT_W-1:0] ext_sync_reg;
    logic             en_meta_reg;
    logic             en_sync_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
            en_meta_reg  <= 1'b0;
            en_sync_reg  <= 1'b0;
        end else begin
            ext_meta_reg <= {rel_time_i, abs_time_i, op_status_i, in_err_i, event_i, alarm_i};
            ext_sync_reg <= ext_meta_reg;
            en_meta_reg  <= calc_enable_i;
            en_sync_reg  <= en_meta_reg;
        end
    end

    logic [bwl_pkg::NUM_ALARMS-1:0] alarm_s;
    logic [bwl_pkg::NUM_EVENTS-1:0] event_s;
    logic [bwl_pkg::NUM_ERRS-1:0]   err_s;
    logic [bwl_pkg::NUM_STATUS-1:0] stat_s;
    logic [bwl_pkg::TIME_SIGS-1:0]  abs_s;
    logic [bwl_pkg::TIME_SIGS-1:0]  rel_s;
    logic [bwl_pkg::NUM_CONSTS-1:0] const_true;
    logic [NRES-1:0]                result_reg;

    assign {rel_s, abs_s, stat_s, err_s, event_s, alarm_s} = ext_sync_reg;

    genvar gi;
    generate
        for (gi = 0; gi < bwl_pkg::NUM_CONSTS; gi++) begin : g_const
            assign const_true[gi] = |user_const_i[gi*bwl_pkg::CONST_W +: bwl_pkg::CONST_W];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------------
    function automatic logic src_bit(input logic [bwl_pkg::CODE_W-1:0] code);
        logic [bwl_pkg::CODE_W-1:0] d;
        d = '0;
        src_bit = 1'b0;
        if (code >= bwl_pkg::SRC_ALARM_LO && code <= bwl_pkg::SRC_ALARM_HI) begin
            d = code - bwl_pkg::SRC_ALARM_LO;
            src_bit = alarm_s[d[2:0]];
        end else if (code >= bwl_pkg::SRC_EVENT_LO && code <= bwl_pkg::SRC_EVENT_HI) begin
            d = code - bwl_pkg::SRC_EVENT_LO;
            src_bit = event_s[d[2:0]];
        end else if (code >= bwl_pkg::SRC_RESULT_LO && code <= bwl_pkg::SRC_RESULT_HI) begin
            d = code - bwl_pkg::SRC_RESULT_LO;
            src_bit = result_reg[d[5:0]];
        end else if (code >= bwl_pkg::SRC_CONST_LO && code <= bwl_pkg::SRC_CONST_HI) begin
            d = code - bwl_pkg::SRC_CONST_LO;
            src_bit = const_true[d[3:0]];
        end else if (code >= bwl_pkg::SRC_ABS_LO && code <= bwl_pkg::SRC_ABS_HI) begin
            d = code - bwl_pkg::SRC_ABS_LO;
            src_bit = abs_s[d[6:0]];
        end else if (code >= bwl_pkg::SRC_REL_LO && code <= bwl_pkg::SRC_REL_HI) begin
            d = code - bwl_pkg::SRC_REL_LO;
            src_bit = rel_s[d[6:0]];
        end else begin
            case (code)
                bwl_pkg::SRC_UNDER:     src_bit = err_s[0];
                bwl_pkg::SRC_OVER:      src_bit = err_s[1];
                bwl_pkg::SRC_RANGE_ERR: src_bit = err_s[2];
                bwl_pkg::SRC_IN_ERR:    src_bit = err_s[3];
                bwl_pkg::SRC_AUTO_MAN:  src_bit = stat_s[0];
                bwl_pkg::SRC_RUN_STBY:  src_bit = stat_s[1];
                bwl_pkg::SRC_AT_RUN:    src_bit = stat_s[2];
                bwl_pkg::SRC_AT_NORM:   src_bit = stat_s[3];
                bwl_pkg::SRC_AT_LOW:    src_bit = stat_s[4];
                default:                src_bit = 1'b0;
            endcase
        end
    endfunction

    // Result code 30..69 to result bit; any other code drives a constant low.
    function automatic logic route_bit(input logic [bwl_pkg::CODE_W-1:0] code);
        logic [bwl_pkg::CODE_W-1:0] d;
        d = code - bwl_pkg::SRC_RESULT_LO;
        route_bit = 1'b0;
        if (code >= bwl_pkg::SRC_RESULT_LO && code <= bwl_pkg::SRC_RESULT_HI) begin
            route_bit = result_reg[d[5:0]];
        end
    endfunction

    // ------------------------------------------------------------------
    // Wafer setting store and scan
    // ------------------------------------------------------------------
    bwl_pkg::bwl_state_e          state_reg;
    logic [bwl_pkg::ADDR_W-1:0]   addr_reg;
    logic [bwl_pkg::ADDR_W-1:0]   eval_idx_reg;
    logic                         eval_vld_reg;
    logic [bwl_pkg::WAFER_CFG_W-1:0] cfg_rd;

    bwl_cfg_mem #(
        .DEPTH (bwl_pkg::NUM_WAFERS),
        .WIDTH (bwl_pkg::WAFER_CFG_W),
        .AW    (bwl_pkg::ADDR_W)
    ) u_cfg_mem (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (cfg_we_i),
        .wr_addr_i (cfg_wafer_i),
        .wr_data_i (cfg_data_i),
        .rd_addr_i (addr_reg),
        .rd_data_o (cfg_rd)
    );

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_reg <= bwl_pkg::BWL_IDLE;
        end else begin
            case (state_reg)
                bwl_pkg::BWL_IDLE: state_reg <= en_sync_reg ? bwl_pkg::BWL_SCAN
                                                            : bwl_pkg::BWL_IDLE;
                bwl_pkg::BWL_SCAN: state_reg <= en_sync_reg ? bwl_pkg::BWL_SCAN
                                                            : bwl_pkg::BWL_IDLE;
                default:           state_reg <= bwl_pkg::BWL_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || state_reg != bwl_pkg::BWL_SCAN) begin
            addr_reg     <= bwl_pkg::ADDR_RESET;
            eval_idx_reg <= bwl_pkg::ADDR_RESET;
            eval_vld_reg <= 1'b0;
        end else begin
            addr_reg     <= (addr_reg == bwl_pkg::ADDR_LAST) ? bwl_pkg::ADDR_RESET
                                                             : addr_reg + 4'h1;
            eval_idx_reg <= addr_reg;
            eval_vld_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Wafer function
    // ------------------------------------------------------------------
    logic [bwl_pkg::TYPE_W-1:0] w_type;
    logic [bwl_pkg::CODE_W-1:0] w_a;
    logic [bwl_pkg::CODE_W-1:0] w_b;
    logic [bwl_pkg::CODE_W-1:0] w_c;
    logic a_bit;
    logic b_bit;
    logic c_bit;
    logic [bwl_pkg::WAFER_OUTS-1:0] f_out;

    assign {w_type, w_c, w_b, w_a} = cfg_rd;
    assign a_bit = src_bit(w_a);
    assign b_bit = src_bit(w_b);
    assign c_bit = src_bit(w_c);

    always_comb begin
        case (w_type)
            bwl_pkg::TYPE_OR3:    f_out = {~(a_bit | b_bit | ~c_bit),
                                           {3{a_bit | b_bit | c_bit}}};
            bwl_pkg::TYPE_AND3:   f_out = {~(a_bit & b_bit & ~c_bit),
                                           {3{a_bit & b_bit & c_bit}}};
            bwl_pkg::TYPE_OR_AND: f_out = {~((a_bit | b_bit) & ~c_bit),
                                           {3{(a_bit | b_bit) & c_bit}}};
            bwl_pkg::TYPE_AND_OR: f_out = {~((a_bit & b_bit) | ~c_bit),
                                           {3{(a_bit & b_bit) | c_bit}}};
            default:              f_out = '0;
        endcase
    end

    // Chained wafers see the stored results: this scan's for lower-numbered wafers, the previous scan's
    // for the rest, so evaluation order never forms a combinational loop between wafers.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || state_reg != bwl_pkg::BWL_SCAN) begin
            result_reg <= '0;
        end else if (eval_vld_reg) begin
            result_reg[eval_idx_reg*bwl_pkg::WAFER_OUTS +: bwl_pkg::WAFER_OUTS] <= f_out;
        end
    end

    // ------------------------------------------------------------------
    // Output routing
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || state_reg != bwl_pkg::BWL_SCAN) begin
            result_o <= '0;
            do_o     <= '0;
            led_o    <= '0;
        end else begin
            result_o <= result_reg;
            for (int i = 0; i < NUM_DO; i++) begin
                do_o[i] <= route_bit(do_sel_i[i*bwl_pkg::CODE_W +: bwl_pkg::CODE_W]);
            end
            for (int j = 0; j < NUM_LED; j++) begin
                led_o[j] <= route_bit(led_sel_i[j*bwl_pkg::CODE_W +: bwl_pkg::CODE_W]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_off_clears: assert property (state_reg == bwl_pkg::BWL_IDLE |=> result_reg == '0)
        else $error("results not cleared while calculation off");
    a_off_outputs: assert property (state_reg == bwl_pkg::BWL_IDLE |=> do_o == '0 && led_o == '0)
        else $error("outputs driven while calculation off");
    a_scan_wrap: assert property (state_reg == bwl_pkg::BWL_SCAN && addr_reg == 4'h9
                                  && en_sync_reg |=> addr_reg == 4'h0)
        else $error("wafer scan did not wrap after wafer ten");
    a_result_store: assert property (eval_vld_reg && state_reg == bwl_pkg::BWL_SCAN |=>
        result_reg[$past(eval_idx_reg)*4 +: 4] == $past(f_out))
        else $error("wafer result not stored");
    a_or3_func: assert property (w_type == bwl_pkg::TYPE_OR3 |->
        f_out[0] == (a_bit | b_bit | c_bit) && f_out[3] == !(a_bit | b_bit | !c_bit))
        else $error("three-input OR wrong");
    a_and_or_func: assert property (w_type == bwl_pkg::TYPE_AND_OR |->
        f_out[2] == ((a_bit & b_bit) | c_bit))
        else $error("AND then OR wrong");
    a_chain_src: assert property (w_a == 9'h01E |-> a_bit == result_reg[0])
        else $error("code 30 not wafer one output one");
    a_last_src: assert property (w_b == 9'h045 |-> b_bit == result_reg[39])
        else $error("code 69 not wafer ten output four");
    a_const_src: assert property (w_c == 9'h046 |-> c_bit == (user_const_i[15:0] != 16'h0000))
        else $error("code 70 not constant one");
    a_none_src: assert property (w_a == 9'h000 |-> !a_bit)
        else $error("no-input code not low");
    a_do_route: assert property (state_reg == bwl_pkg::BWL_SCAN && en_sync_reg
        && do_sel_i[8:0] == 9'h045 |=> do_o[0] == $past(result_reg[39]))
        else $error("output routing wrong");
    a_led_route: assert property (state_reg == bwl_pkg::BWL_SCAN
        && led_sel_i[8:0] == 9'h01E |=> led_o[0] == $past(result_reg[0]))
        else $error("lamp routing wrong");

    c_enable_on: cover property (state_reg == bwl_pkg::BWL_IDLE ##1 state_reg == bwl_pkg::BWL_SCAN);
    c_full_scan: cover property (eval_vld_reg && eval_idx_reg == 4'h9);
    c_do_high:   cover property (do_o[0]);
    c_chain_use: cover property (eval_vld_reg && w_a == 9'h01E && a_bit);
endmodule // bwl_wafer_unit

// >>> sim/boolean_wafer_logic_unit_tb.sv
`timescale 1ns/10ps
module boolean_wafer_logic_unit_tb;
    logic          ref_clk_i;
    logic          nrst_i;
    logic          calc_enable_i;
    logic          cfg_we_i;
    logic [3:0]    cfg_wafer_i;
    logic [29:0]   cfg_data_i;
    logic [159:0]  user_const_i;
    logic [4:0]    alarm_i;
    logic [4:0]    event_i;
    logic [3:0]    in_err_i;
    logic [4:0]    op_status_i;
    logic [127:0]  abs_time_i;
    logic [127:0]  rel_time_i;
    logic [35:0]   do_sel_i;
    logic [35:0]   led_sel_i;
    logic [39:0]   result_o;
    logic [3:0]    do_o;
    logic [3:0]    led_o;
    int            failures;
    int            total_checks;
    int            codes [30] = '{3, 4, 5, 6, 7, 20, 21, 22, 23, 24, 70, 75, 79, 94, 95, 98, 103,
                                  104, 105, 107, 108, 109, 170, 171, 296, 297, 300, 301, 426, 427};

    bwl_wafer_unit i_bwl_wafer_unit (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .calc_enable_i(calc_enable_i), .cfg_we_i(cfg_we_i), .cfg_wafer_i(cfg_wafer_i),
        .cfg_data_i(cfg_data_i), .user_const_i(user_const_i), .alarm_i(alarm_i),
        .event_i(event_i), .in_err_i(in_err_i), .op_status_i(op_status_i),
        .abs_time_i(abs_time_i), .rel_time_i(rel_time_i), .do_sel_i(do_sel_i),
        .led_sel_i(led_sel_i), .result_o(result_o), .do_o(do_o), .led_o(led_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic write_wafer(input int w, input int t, input int a, input int b, input int c);
        @(negedge ref_clk_i);
        cfg_we_i    = 1'b1;
        cfg_wafer_i = 4'(w);
        cfg_data_i  = {3'(t), 9'(c), 9'(b), 9'(a)};
        @(negedge ref_clk_i);
        cfg_we_i    = 1'b0;
    endtask

    // Refresh takes ten cycles plus sync and pipeline, so forty is ample margin.
    task automatic settle();
        repeat (40) @(negedge ref_clk_i);
    endtask

    // Drives the one source of the given code true, or none for code 0; all others false.
    task automatic set_src(input int code);
        @(negedge ref_clk_i);
        alarm_i = '0; event_i = '0; in_err_i = '0; op_status_i = '0;
        abs_time_i = '0; rel_time_i = '0; user_const_i = '0;
        if (code >= 3 && code <= 7) alarm_i[code-3] = 1'b1;
        if (code >= 20 && code <= 24) event_i[code-20] = 1'b1;
        if (code >= 70 && code <= 79) user_const_i[16*(code-70) +: 16] = 16'h8000;
        if (code == 94) in_err_i[0] = 1'b1;
        if (code == 95) in_err_i[1] = 1'b1;
        if (code == 98) in_err_i[2] = 1'b1;
        if (code == 103) in_err_i[3] = 1'b1;
        if (code >= 104 && code <= 109 && code != 106) op_status_i[code-104-(code>106)] = 1'b1;
        if (code >= 170 && code <= 297) abs_time_i[code-170] = 1'b1;
        if (code >= 300 && code <= 427) rel_time_i[code-300] = 1'b1;
    endtask

    function automatic logic [3:0] wexp(input int t, input logic a, input logic b, input logic c);
        logic f;
        logic g;
        case (t)
            2: begin f = a | b | c; g = a | b | ~c; end
            3: begin f = a & b & c; g = a & b & ~c; end
            4: begin f = (a | b) & c; g = (a | b) & ~c; end
            5: begin f = a & b | c; g = a & b | ~c; end
            default: return 4'h0;
        endcase
        return {~g, f, f, f};
    endfunction

    task automatic chk_res(input int w, input logic [3:0] exp, input string msg);
        total_checks++;
        if (result_o[4*w +: 4] !== exp) begin
            failures++;
            $display("[FAIL] %0t %s wafer %0d got %b exp %b", $time, msg, w, result_o[4*w +: 4], exp);
        end
    endtask

    task automatic chk_pins(input logic [7:0] exp, input string msg);
        total_checks++;
        if ({led_o, do_o} !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, {led_o, do_o}, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        failures = 0; total_checks = 0;
        nrst_i = 1'b0; calc_enable_i = 1'b0; cfg_we_i = 1'b0; cfg_wafer_i = '0; cfg_data_i = '0;
        user_const_i = '0; alarm_i = '0; event_i = '0; in_err_i = '0; op_status_i = '0;
        abs_time_i = '0; rel_time_i = '0;
        do_sel_i = {9'd0, 9'd70, 9'd66, 9'd69};
        led_sel_i = {9'd0, 9'd0, 9'd0, 9'd30};
        for (int w = 0; w < 10; w++) write_wafer(w, 0, 0, 0, 0);
        chk_pins(8'h00, "pins in reset");
        nrst_i = 1'b1;
        calc_enable_i = 1'b1;
        for (int t = 0; t < 8; t++) begin
            write_wafer(0, t, 3, 4, 5);
            for (int p = 0; p < 8; p++) begin
                @(negedge ref_clk_i);
                alarm_i = {2'b00, 3'(p)};
                settle();
                chk_res(0, wexp(t, p[0], p[1], p[2]), "type table");
            end
        end
        $display("test types done");
        write_wafer(1, 2, 0, 0, 0);
        for (int i = 0; i < 30; i++) begin
            write_wafer(1, 2, codes[i], 0, 0);
            set_src(codes[i]);
            settle();
            chk_res(1, 4'b0111, "source selected");
            set_src(0);
            settle();
            chk_res(1, 4'b0000, "source cleared");
        end
        $display("test sources done");
        write_wafer(0, 2, 3, 0, 0);
        write_wafer(1, 0, 0, 0, 0);
        write_wafer(9, 4, 30, 0, 0);
        write_wafer(10, 3, 0, 0, 0);
        set_src(3);
        settle();
        chk_res(0, 4'b0111, "index above nine ignored");
        chk_res(9, 4'b0000, "chain set");
        chk_pins(8'h10, "routing set");
        set_src(0);
        settle();
        chk_res(9, 4'b1000, "chain clear");
        chk_pins(8'h01, "routing clear");
        $display("test chain done");
        set_src(3);
        @(negedge ref_clk_i);
        calc_enable_i = 1'b0;
        settle();
        total_checks++;
        if (result_o !== 40'h00_0000_0000) begin
            failures++;
            $display("[FAIL] %0t results not cleared when disabled", $time);
        end
        chk_pins(8'h00, "pins when disabled");
        $display("test disable done");
        give_verdict();
    end
endmodule // boolean_wafer_logic_unit_tb
